/* rtl/pcie_cap2_aer_status_regs.sv */
// cap2 control/status and error reporting register bank for one port
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "cap2_aer_map.svh"

module pcie_cap2_aer_status_regs (
   input wire logic clk,
   input wire logic srst,
   input wire logic por_rst,
   input wire logic downstream_port,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire cap2_aer_pkg::uerr_evt_t err_evt,
   input wire logic cur_deemph_level,
   output cap2_aer_pkg::dev_ctl_t dev_ctl,
   output cap2_aer_pkg::link_ctl_t link_ctl,
   output logic [31:0] uerr_flags
);

   logic ds_port_q;
   logic ltr_en_q;
   logic [1:0] obff_q;
   logic [3:0] tls_q;
   logic ent_comp_q;
   logic hw_dis_q;
   logic deemph_sel_q;
   logic [2:0] margin_q;
   logic mod_comp_q;
   logic comp_sos_q;
   logic comp_deemph_q;
   logic [31:0] uerr_q;
   logic [31:0] uerr_set;
   logic [31:0] uerr_clr;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [15:0] dev_ctl2_rd;
   logic [15:0] link_ctl2_rd;
   logic [15:0] link_sts2_rd;
   logic wr_dev;
   logic wr_link;
   logic wr_uerr;

   // reset images as vectors so single fields can be picked out of them
   localparam logic [15:0] dev_ctl2_rst = `DEV_CTL2_RST;
   localparam logic [31:0] uerr_rst = `UERR_RST;
   localparam logic [31:0] uerr_impl = `UERR_IMPL;

   // address decode of the write strobe
   assign wr_dev = wr_en && (addr == `OFF_DEV_CTL2);
   assign wr_link = wr_en && (addr == `OFF_LINK_CTL2);
   assign wr_uerr = wr_en && (addr == `OFF_UERR);

   // port type strap is caught while the port reset is held
   // so a strap that moves later cannot unmask surprise down
   always_ff @(posedge clk) begin
      if (srst) begin
         ds_port_q <= downstream_port;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ltr_en_q <= dev_ctl2_rst[`LTR_EN_BIT];
         obff_q <= dev_ctl2_rst[`OBFF_MSB:`OBFF_LSB];
      end else if (wr_dev) begin
         ltr_en_q <= wdata[`LTR_EN_BIT];
         obff_q <= wdata[`OBFF_MSB:`OBFF_LSB];
      end
   end

   // deemphasis select set by port type
   always_ff @(posedge clk) begin
      if (srst) begin
         deemph_sel_q <= downstream_port;
      end
   end

   // non-sticky link control bit
   always_ff @(posedge clk) begin
      if (srst) begin
         hw_dis_q <= 1'b0;
      end else if (wr_link) begin
         hw_dis_q <= wdata[`HW_DIS_BIT];
      end
   end

   // sticky link fields, reset by power only
   // so target speed and margins ride through a port reset
   always_ff @(posedge clk) begin
      if (por_rst) begin
         tls_q <= `TLS_RST;
         ent_comp_q <= 1'b0;
         margin_q <= `MARGIN_RST;
         mod_comp_q <= 1'b0;
         comp_sos_q <= 1'b0;
         comp_deemph_q <= 1'b0;
      end else if (wr_link) begin
         tls_q <= wdata[`TLS_MSB:`TLS_LSB];
         ent_comp_q <= wdata[`ENT_COMP_BIT];
         margin_q <= wdata[`MARGIN_MSB:`MARGIN_LSB];
         mod_comp_q <= wdata[`MOD_COMP_BIT];
         comp_sos_q <= wdata[`COMP_SOS_BIT];
         comp_deemph_q <= wdata[`COMP_DEEMPH_BIT];
      end
   end

   // map event pulses onto flag positions
   always_comb begin
      uerr_set = 32'h0000_0000;
      uerr_set[`UE_TRAIN] = err_evt.training;
      uerr_set[`UE_DLP] = err_evt.dl_protocol;
      uerr_set[`UE_SDN] = err_evt.surprise_down & ds_port_q;
      uerr_set[`UE_PSN] = err_evt.poisoned;
      uerr_set[`UE_FCP] = err_evt.fc_protocol;
      uerr_set[`UE_CTO] = err_evt.cpl_timeout;
      uerr_set[`UE_CA] = err_evt.cpl_abort;
      uerr_set[`UE_UC] = err_evt.unexp_cpl;
      uerr_set[`UE_RXO] = err_evt.rx_overflow;
      uerr_set[`UE_MAL] = err_evt.malformed;
      uerr_set[`UE_ECRC] = err_evt.ecrc;
      uerr_set[`UE_UR] = err_evt.unsupported;
      uerr_set[`UE_ACS] = err_evt.acs_violation;
   end

   // clear mask, live only in the cycle of a write to the flag word
   assign uerr_clr = wr_uerr ? wdata : 32'h0000_0000;

   // sticky write-one-to-clear flags, set wins over clear
   generate
      for (genvar i = 0; i < 32; i++) begin : g_uerr
         if (uerr_impl[i]) begin : g_impl
            always_ff @(posedge clk) begin
               if (por_rst) begin
                  uerr_q[i] <= uerr_rst[i];
               end else begin
                  uerr_q[i] <= (uerr_q[i] & ~uerr_clr[i]) | uerr_set[i];
               end
            end
         end else begin : g_rsvd
            assign uerr_q[i] = 1'b0;
         end
      end
   endgenerate

   // read views of the mixed halfwords
   // reserved places are tied here; read-only deemph_sel_q is a flop, cur_deemph_level a live input
   assign dev_ctl2_rd = {1'b0, obff_q, 2'b00, ltr_en_q, 10'h000};
   assign link_ctl2_rd = {3'b000, comp_deemph_q, comp_sos_q, mod_comp_q,
                          margin_q, deemph_sel_q, hw_dis_q, ent_comp_q,
                          tls_q};
   assign link_sts2_rd = {15'h0000, cur_deemph_level};

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (addr)
         `OFF_DEV_CTL2: rdata_d = {`DEV_STS2_RST, dev_ctl2_rd};
         `OFF_LINK_CAP2: rdata_d = `LINK_CAP2_RST;
         `OFF_LINK_CTL2: rdata_d = {link_sts2_rd, link_ctl2_rd};
         `OFF_SLOT_CAP2: rdata_d = `SLOT_CAP2_RST;
         `OFF_SLOT_CTL2: rdata_d = {`SLOT_STS2_RST, `SLOT_CTL2_RST};
         `OFF_ERR_HDR: rdata_d = {`ERR_NEXT_PTR, `ERR_CAP_VER, `ERR_CAP_ID};
         `OFF_UERR: rdata_d = uerr_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   // zero between reads keeps a stale word from passing as an answer
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_en) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // outputs from flops
   assign rdata = rdata_q;
   assign uerr_flags = uerr_q;
   assign dev_ctl.ltr_enable = ltr_en_q;
   assign dev_ctl.obff_mode = obff_q;
   assign link_ctl.target_link_speed = tls_q;
   assign link_ctl.enter_compliance = ent_comp_q;
   assign link_ctl.hw_speed_change_disable = hw_dis_q;
   assign link_ctl.deemph_select = deemph_sel_q;
   assign link_ctl.tx_margin = margin_q;
   assign link_ctl.enter_modified_compliance = mod_comp_q;
   assign link_ctl.compliance_sos = comp_sos_q;
   assign link_ctl.compliance_deemph = comp_deemph_q;

   // helper: flags that fell without a matching write-one
   logic [31:0] uerr_prev_q;
   logic [31:0] uerr_clr_prev_q;
   always_ff @(posedge clk) begin
      uerr_prev_q <= uerr_q;
      uerr_clr_prev_q <= uerr_clr;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst || por_rst);

   // checks on the control halfwords and the error header
   dev_ctl_rsvd_a: assert property (
      rd_en && addr == `OFF_DEV_CTL2 |=>
      rdata[15] == 1'b0 && rdata[12:11] == 2'b00 && rdata[9:0] == 10'h000 &&
      rdata[14:13] == obff_q && rdata[10] == ltr_en_q)
      else $error("device control two read wrong");
   dev_ctl_write_a: assert property (
      wr_dev |=> dev_ctl.obff_mode == $past(wdata[14:13]) &&
      dev_ctl.ltr_enable == $past(wdata[10]))
      else $error("device control two write lost");
   deemph_reset_a: assert property (
      $fell(srst) |-> link_ctl.deemph_select == $past(downstream_port))
      else $error("deemphasis select reset value wrong");
   deemph_ro_a: assert property (
      wr_link |=> link_ctl.deemph_select == $past(deemph_sel_q))
      else $error("deemphasis select changed by write");
   hdr_id_a: assert property (
      rd_en && addr == `OFF_ERR_HDR |=> rdata[15:0] == 16'h0001)
      else $error("capability id wrong");
   hdr_version_a: assert property (
      rd_en && addr == `OFF_ERR_HDR |=> rdata[19:16] == 4'h1)
      else $error("capability version wrong");
   hdr_next_a: assert property (
      rd_en && addr == `OFF_ERR_HDR |=> rdata[31:20] == 12'h140)
      else $error("next capability pointer wrong");

   // each event sets its flag on the next edge, surprise down only on a downstream port
   train_flag_a: assert property (
      err_evt.training |=> uerr_flags[0]) else $error("bit 0 not set");
   dlp_flag_a: assert property (
      err_evt.dl_protocol |=> uerr_flags[4]) else $error("bit 4 not set");
   sdn_flag_a: assert property (
      err_evt.surprise_down |=> uerr_flags[5] == ($past(ds_port_q) ||
      ($past(uerr_q[5]) && !$past(uerr_clr[5]))))
      else $error("bit 5 wrong");
   psn_flag_a: assert property (
      err_evt.poisoned |=> uerr_flags[12]) else $error("bit 12 not set");
   fcp_flag_a: assert property (
      err_evt.fc_protocol |=> uerr_flags[13]) else $error("bit 13 not set");
   cto_flag_a: assert property (
      err_evt.cpl_timeout |=> uerr_flags[14]) else $error("bit 14 not set");
   ca_flag_a: assert property (
      err_evt.cpl_abort |=> uerr_flags[15]) else $error("bit 15 not set");
   uc_flag_a: assert property (
      err_evt.unexp_cpl |=> uerr_flags[16]) else $error("bit 16 not set");
   rxo_flag_a: assert property (
      err_evt.rx_overflow |=> uerr_flags[17]) else $error("bit 17 not set");
   mal_flag_a: assert property (
      err_evt.malformed |=> uerr_flags[18]) else $error("bit 18 not set");
   ecrc_flag_a: assert property (
      err_evt.ecrc |=> uerr_flags[19]) else $error("bit 19 not set");
   ur_flag_a: assert property (
      err_evt.unsupported |=> uerr_flags[20]) else $error("bit 20 not set");
   acs_flag_a: assert property (
      err_evt.acs_violation |=> uerr_flags[21]) else $error("bit 21 not set");

   // flags fall only under a write-one, survive port reset
   flag_clear_a: assert property (
      @(posedge clk) disable iff (por_rst)
      ##1 (uerr_prev_q & ~uerr_q & ~uerr_clr_prev_q) == 32'h0000_0000)
      else $error("flag cleared without write-one");
   flag_rsvd_a: assert property (
      (uerr_flags & ~`UERR_IMPL) == 32'h0000_0000)
      else $error("reserved flag bit set");
   speed_reset_a: assert property (@(posedge clk)
      $fell(por_rst) |-> link_ctl.target_link_speed == 4'h2 &&
      !link_ctl.enter_compliance && link_ctl.tx_margin == 3'h0)
      else $error("sticky link field reset wrong");

   // control halfwords: hold, reset and read views
   dev_ctl_hold_a: assert property (
      !wr_dev |=> $stable(dev_ctl))
      else $error("device control two moved without a write");
   dev_ctl_reset_a: assert property (
      $fell(srst) |-> !dev_ctl.ltr_enable && dev_ctl.obff_mode == 2'b00)
      else $error("device control two reset value wrong");
   dev_sts_zero_a: assert property (
      rd_en && addr == `OFF_DEV_CTL2 |=> rdata[31:16] == 16'h0000)
      else $error("device status two not zero");
   deemph_stable_a: assert property (
      1'b1 |=> $stable(link_ctl.deemph_select))
      else $error("deemphasis select moved outside reset");
   link_ctl_rsvd_a: assert property (
      rd_en && addr == `OFF_LINK_CTL2 |=>
      rdata[15:13] == 3'b000 && rdata[31:17] == 15'h0000)
      else $error("link control two reserved bits set");
   sticky_keep_a: assert property (
      @(posedge clk) disable iff (por_rst)
      srst && !wr_link |=> $stable(link_ctl.target_link_speed) &&
      $stable(link_ctl.tx_margin) && $stable(link_ctl.enter_compliance))
      else $error("sticky link field lost in port reset");

   // flag register: upstream mask, clear, survival and power reset
   sdn_upstream_a: assert property (
      !ds_port_q && !uerr_q[5] |=> !uerr_flags[5])
      else $error("surprise down flag set on upstream port");
   flag_w1c_a: assert property (
      wr_uerr && err_evt == '0 |=>
      (uerr_flags & $past(wdata)) == 32'h0000_0000)
      else $error("write-one did not clear a flag");
   flags_keep_a: assert property (
      @(posedge clk) disable iff (por_rst)
      srst && !wr_uerr |=>
      (uerr_flags & $past(uerr_flags)) == $past(uerr_flags))
      else $error("flag lost in port reset");
   flags_reset_a: assert property (
      $fell(por_rst) |-> uerr_flags == 32'h0000_0000)
      else $error("flags not cleared by power reset");

   // a set flag holds until its own write-one arrives
   generate
      for (genvar j = 0; j < 32; j++) begin : g_hold
         if (uerr_impl[j]) begin : g_chk
            flag_hold_a: assert property (
               uerr_q[j] && !uerr_clr[j] |=> uerr_flags[j])
               else $error("flag dropped without write-one");
         end
      end
   endgenerate

   // main scenarios
   flag_w1c_c: cover property (uerr_flags[14] ##1 wr_uerr && wdata[14]
      ##1 !uerr_flags[14]);
   set_clear_race_c: cover property (wr_uerr && wdata[0] &&
      err_evt.training ##1 uerr_flags[0]);
   hdr_read_c: cover property (rd_en && addr == `OFF_ERR_HDR);
   speed_write_c: cover property (wr_link ##1 rd_en && addr == `OFF_LINK_CTL2);
   port_reset_c: cover property (@(posedge clk) disable iff (por_rst)
      $fell(srst) && uerr_flags != 32'h0000_0000);

endmodule

/* rtl/cap2_aer_map.svh */
// register offsets, field positions and reset values of the cap2/aer bank
`ifndef CAP2_AER_MAP_SVH
`define CAP2_AER_MAP_SVH
`define ADDR_W 12
`define OFF_DEV_CTL2 12'h0e8
`define OFF_LINK_CAP2 12'h0ec
`define OFF_LINK_CTL2 12'h0f0
`define OFF_SLOT_CAP2 12'h0f4
`define OFF_SLOT_CTL2 12'h0f8
`define OFF_ERR_HDR 12'h100
`define OFF_UERR 12'h104
`define LTR_EN_BIT 10
`define OBFF_LSB 13
`define OBFF_MSB 14
`define DEV_CTL2_RST 16'h0000
`define DEV_STS2_RST 16'h0000
`define LINK_CAP2_RST 32'h0000_0000
`define SLOT_CAP2_RST 32'h0000_0000
`define SLOT_CTL2_RST 16'h0000
`define SLOT_STS2_RST 16'h0000
`define TLS_LSB 0
`define TLS_MSB 3
`define TLS_RST 4'h2
`define ENT_COMP_BIT 4
`define HW_DIS_BIT 5
`define DEEMPH_SEL_BIT 6
`define MARGIN_LSB 7
`define MARGIN_MSB 9
`define MARGIN_RST 3'h0
`define MOD_COMP_BIT 10
`define COMP_SOS_BIT 11
`define COMP_DEEMPH_BIT 12
`define CUR_DEEMPH_BIT 16
`define ERR_CAP_ID 16'h0001
`define ERR_CAP_VER 4'h1
`define ERR_NEXT_PTR 12'h140
`define UE_TRAIN 0
`define UE_DLP 4
`define UE_SDN 5
`define UE_PSN 12
`define UE_FCP 13
`define UE_CTO 14
`define UE_CA 15
`define UE_UC 16
`define UE_RXO 17
`define UE_MAL 18
`define UE_ECRC 19
`define UE_UR 20
`define UE_ACS 21
`define UERR_IMPL 32'h003f_f031
`define UERR_RST 32'h0000_0000
`endif

/* rtl/cap2_aer_pkg.sv */
// types shared by the cap2/aer register bank and its users
package cap2_aer_pkg;
   // one-cycle error event pulses from link, transaction and flow control
   typedef struct packed {
      logic training;
      logic dl_protocol;
      logic surprise_down;
      logic poisoned;
      logic fc_protocol;
      logic cpl_timeout;
      logic cpl_abort;
      logic unexp_cpl;
      logic rx_overflow;
      logic malformed;
      logic ecrc;
      logic unsupported;
      logic acs_violation;
   } uerr_evt_t;

   // device control two settings driven to the port core
   typedef struct packed {
      logic ltr_enable;
      logic [1:0] obff_mode;
   } dev_ctl_t;

   // link control two settings driven to the link training logic
   typedef struct packed {
      logic [3:0] target_link_speed;
      logic enter_compliance;
      logic hw_speed_change_disable;
      logic deemph_select;
      logic [2:0] tx_margin;
      logic enter_modified_compliance;
      logic compliance_sos;
      logic compliance_deemph;
   } link_ctl_t;
endpackage

/* bench/pcie_cap2_aer_status_regs_test.sv */
// self-checking bench for the cap2/aer register bank
`timescale 1ns/1ps

module pcie_cap2_aer_status_regs_test;
   logic clk = 1'b0;
   logic srst, por_rst, downstream_port, wr_en, rd_en, cur_deemph_level;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, uerr_flags, ex, wd;
   cap2_aer_pkg::uerr_evt_t err_evt;
   cap2_aer_pkg::dev_ctl_t dev_ctl;
   cap2_aer_pkg::link_ctl_t link_ctl;
   logic [12:0] lc_rw, v;
   logic [14:0] e8_rw;
   logic ds;
   integer seed = 32'h3968;
   int fails = 0;
   int checks_done = 0;

   pcie_cap2_aer_status_regs u_pcie_cap2_aer_status_regs (.clk(clk),
      .srst(srst), .por_rst(por_rst), .downstream_port(downstream_port),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .err_evt(err_evt), .cur_deemph_level(cur_deemph_level),
      .dev_ctl(dev_ctl), .link_ctl(link_ctl), .uerr_flags(uerr_flags));

   // 100 MHz core clock
   always #5 clk = ~clk;

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask

   // one-cycle read strobe, data checked in the following cycle
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // reset pulse of five cycles, optionally including power reset
   task automatic rst(input logic d, input logic p);
      @(posedge clk);
      srst <= 1'b1;
      por_rst <= p;
      downstream_port <= d;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      por_rst <= 1'b0;
      #1;
      ds = d;
      lc_rw[5] = 1'b0;
      e8_rw = '0;
      if (p) begin
         lc_rw = 13'h0002;
         ex = '0;
      end
   endtask

   // event vector to expected flag bits
   function automatic logic [31:0] fmap(input logic [12:0] e,
                                        input logic d);
      int pos[13] = '{0, 4, 5, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
      fmap = '0;
      for (int i = 0; i < 13; i++) begin
         if (e[12 - i] && (i != 2 || d))
            fmap[pos[i]] = 1'b1;
      end
   endfunction

   // expected word at f0
   function automatic logic [31:0] f0_exp();
      return {15'h0, cur_deemph_level, 3'h0, lc_rw[12:7], ds, lc_rw[5:0]};
   endfunction

   // check the control outputs against the model
   task automatic chk_ctl();
      chk({29'h0, dev_ctl}, {29'h0, e8_rw[10], e8_rw[14:13]});
      chk({19'h0, link_ctl}, {19'h0, lc_rw[3:0], lc_rw[4], lc_rw[5], ds,
          lc_rw[9:7], lc_rw[10], lc_rw[11], lc_rw[12]});
   endtask

   // event pulse, optionally with a same-cycle clear
   task automatic evt(input logic [12:0] e, input logic clr,
                      input logic [31:0] d);
      @(posedge clk);
      err_evt <= cap2_aer_pkg::uerr_evt_t'(e);
      addr <= 12'h104;
      wdata <= d;
      wr_en <= clr;
      @(posedge clk);
      err_evt <= '0;
      wr_en <= 1'b0;
      #1;
      if (clr)
         ex = ex & ~d;
      ex = ex | fmap(e, ds);
   endtask

   // hang guard
   initial begin
      #900us;
      fails++;
      conclude();
   end

   initial begin
      {srst, por_rst, downstream_port, wr_en, rd_en} = 5'h18;
      {cur_deemph_level, addr, wdata} = '0;
      err_evt = '0;
      rst(1'b1, 1'b1);
      // reset values, unmapped places and idle read data
      rd(12'h0e8, 32'h0000_0000);
      rd(12'h0f0, 32'h0000_0042);
      chk_ctl();
      rd(12'h100, 32'h1401_0001);
      @(posedge clk);
      #1;
      chk(rdata, 32'h0);
      rd(12'h0ec, 32'h0);
      rd(12'h0f4, 32'h0);
      rd(12'h0f8, 32'h0);
      rd(12'h104, 32'h0);
      wr(12'h108, 32'hffff_ffff);
      rd(12'h108, 32'h0);
      rd(12'h104, 32'h0);
      $display("reset values done");
      // random control writes and header write attempts
      for (int i = 0; i < 10; i++) begin
         wd = $random(seed);
         wr(12'h0e8, wd);
         e8_rw = wd[14:0] & 15'h6400;
         wd = $random(seed);
         wr(12'h0f0, wd);
         lc_rw = wd[12:0] & 13'h1fbf;
         cur_deemph_level <= wd[20];
         wr(12'h100, wd);
         rd(12'h0e8, {17'h0, e8_rw});
         rd(12'h0f0, f0_exp());
         rd(12'h100, 32'h1401_0001);
         chk_ctl();
      end
      $display("control writes done");
      // each event alone, then clear all
      for (int i = 0; i < 13; i++) begin
         evt(13'h1 << i, 1'b0, '0);
         chk(uerr_flags, ex);
      end
      chk(uerr_flags, 32'h003f_f031);
      rd(12'h104, 32'h003f_f031);
      evt('0, 1'b1, 32'hffff_ffff);
      chk(uerr_flags, 32'h0);
      $display("single events done");
      // random events mixed with clears, same-cycle set wins
      for (int i = 0; i < 40; i++) begin
         wd = $random(seed);
         v = wd[12:0];
         wd = $random(seed);
         evt(v, wd[31], wd);
         chk(uerr_flags, ex);
      end
      ex = ex | fmap(13'h1fff, 1'b1);
      evt(13'h1fff, 1'b1, 32'hffff_ffff);
      chk(uerr_flags, ex);
      rd(12'h104, ex);
      $display("random events done");
      // port reset as upstream: flags and sticky fields survive
      wr(12'h0f0, 32'h0000_1fbf);
      lc_rw = 13'h1fbf;
      rst(1'b0, 1'b0);
      chk(uerr_flags, ex);
      rd(12'h0f0, f0_exp());
      chk_ctl();
      evt('0, 1'b1, 32'hffff_ffff);
      evt(13'h0400, 1'b0, '0);
      chk(uerr_flags, 32'h0);
      evt(13'h0001, 1'b0, '0);
      chk(uerr_flags, 32'h0020_0000);
      $display("port reset done");
      // power reset restores sticky fields and clears flags
      rst(1'b1, 1'b1);
      chk(uerr_flags, 32'h0);
      rd(12'h0f0, f0_exp());
      chk_ctl();
      $display("power reset done");
      conclude();
   end
endmodule
